// *** logic/crs_map.svh ***
/*
 * core register set constants: resets, vectors, flag bits.
 * assumes inclusion by bare name; crs_ macros are ours alone.
 */
// Contract
// - 8-bit accumulator feeds and takes ALU results
// - 16-bit index pair forms indexed addresses
// - stack pointer resets to 00FF
// - stack low reload sets low byte FF
// - push decrements, pull increments stack pointer
// - stack offset added to stack pointer
// - program counter increments or loads target
// - reset loads counter from FFFE and FFFF
// - flags hold mask, five flags, bits 6,5 one
// - overflow flag feeds signed branches
// - half carry from bit 3 on adds
// - mask blocks interrupts, set after stacking
// - interrupt entry never stacks upper index byte
// - interrupt return pulls flags including mask
// - reset sets mask; clear op, wait/stop or a flags pull clears it
// - highest priority pending request served first
// - negative flag equals result bit 7
// - zero flag set on 00 result
// - carry from bit 7, borrow, shifts
// - registers reachable only through instructions
// - wait/stop clear mask and halt clock
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

`define CRS_ACC_RESET 8'h00
`define CRS_INDEX_RESET 16'h0000
`define CRS_SP_RESET 16'h00FF
`define CRS_SP_LOW_RELOAD 8'hFF
`define CRS_SP_STEP_DOWN 16'hFFFF
`define CRS_ONE16 16'h0001
`define CRS_PC_RESET 16'h0000
`define CRS_VEC_RESET_HI 16'hFFFE
`define CRS_VEC_IRQ_TOP 16'hFFFA
`define CRS_FLAG_V 7
`define CRS_FLAG_H 4
`define CRS_FLAG_I 3
`define CRS_FLAG_N 2
`define CRS_FLAG_Z 1
`define CRS_FLAG_C 0
`define CRS_FLAG_ONES 8'h60
`define CRS_FLAGS_RESET 8'h68
`define CRS_PUSH_LAST 3'h4

`endif

// *** logic/crs_pkg.sv ***
/*
 * core register set types: commands, pull targets, alu ops, states.
 * assumes nothing of its surroundings.
 */
package crs_pkg;

    typedef enum logic [4:0] {
        op_nop = 5'h00, op_load_acc = 5'h01, op_load_index_lo = 5'h02,
        op_load_index_hi = 5'h03, op_alu = 5'h04, op_alu_compare = 5'h05,
        op_fetch = 5'h06, op_jump = 5'h07, op_branch = 5'h08,
        op_push = 5'h09, op_pull = 5'h0A, op_stack_low_reload = 5'h0B,
        op_mask_clear = 5'h0C, op_mask_set = 5'h0D, op_addr_stack = 5'h0E,
        op_addr_index = 5'h0F, op_wait_stop = 5'h10,
        op_push_upper_index = 5'h11, op_pull_upper_index = 5'h12
    } crs_op_t;

    typedef enum logic [2:0] {
        dest_acc = 3'h0, dest_index_lo = 3'h1, dest_index_hi = 3'h2,
        dest_flags = 3'h3, dest_pc_hi = 3'h4, dest_pc_lo = 3'h5,
        dest_none = 3'h7
    } crs_dest_t;

    typedef enum logic [3:0] {
        alu_add = 4'h0, alu_adc = 4'h1, alu_sub = 4'h2, alu_sbc = 4'h3,
        alu_and = 4'h4, alu_or = 4'h5, alu_xor = 4'h6, alu_shl = 4'h7,
        alu_shr = 4'h8, alu_rol = 4'h9, alu_ror = 4'hA, alu_pass = 4'hB
    } crs_alu_op_t;

    typedef enum logic [2:0] {
        st_vec_hi = 3'b000, st_vec_lo = 3'b001, st_vec_wait = 3'b010,
        st_vec_end = 3'b011, st_run = 3'b100, st_int_push = 3'b101,
        st_halt = 3'b110, st_int_mask = 3'b111
    } crs_state_t;

endpackage : crs_pkg

// *** logic/crs_alu_if.sv ***
/*
 * register set to flag unit link.
 * assumes one core end and one unit end on the same clock.
 */
`timescale 1ns/1ps
interface crs_alu_if;
    crs_pkg::crs_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
    logic [7:0] result;
    logic [4:0] flags; // v h n z c
    logic [4:0] affect; // which of v h n z c the op writes

    modport core (output op, output a, output b, output carry_in,
                  input result, input flags, input affect);
    modport unit (input op, input a, input b, input carry_in,
                  output result, output flags, output affect);
endinterface : crs_alu_if

// *** logic/crs_alu.sv ***
/*
 * purely combinational alu and flag generator.
 * assumes the core drives operands and stores the answer.
 */
`timescale 1ns/1ps
module crs_alu (
    // operands and answer
    crs_alu_if.unit bus
);
    logic is_sub;
    logic use_c;
    logic [7:0] bx;
    logic cx;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] res;
    logic c_out;
    logic v_out;
    logic [4:0] aff;

    // subtraction runs as a plus inverted b plus inverted borrow
    assign is_sub = (bus.op == crs_pkg::alu_sub) || (bus.op == crs_pkg::alu_sbc);
    assign use_c = (bus.op == crs_pkg::alu_adc) || (bus.op == crs_pkg::alu_sbc);
    assign bx = is_sub ? ~bus.b : bus.b;
    assign cx = is_sub ? ~(use_c & bus.carry_in) : (use_c & bus.carry_in);
    assign sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, cx};
    assign low = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};

    // result, carry, overflow
    always_comb begin
        res = bus.b;
        c_out = bus.carry_in;
        v_out = 1'b0;
        aff = 5'h16;
        case (bus.op)
            crs_pkg::alu_add, crs_pkg::alu_adc, crs_pkg::alu_sub, crs_pkg::alu_sbc: begin
                res = sum[7:0];
                c_out = is_sub ? ~sum[8] : sum[8];
                v_out = (bus.a[7] == bx[7]) && (sum[7] != bus.a[7]);
                aff = is_sub ? 5'h17 : 5'h1F; // half carry only on adds
            end
            crs_pkg::alu_and: res = bus.a & bus.b;
            crs_pkg::alu_or: res = bus.a | bus.b;
            crs_pkg::alu_xor: res = bus.a ^ bus.b;
            crs_pkg::alu_shl, crs_pkg::alu_rol: begin
                res = {bus.a[6:0], (bus.op == crs_pkg::alu_rol) & bus.carry_in};
                c_out = bus.a[7];
                v_out = bus.a[7] ^ bus.a[6];
                aff = 5'h17;
            end
            crs_pkg::alu_shr, crs_pkg::alu_ror: begin
                res = {(bus.op == crs_pkg::alu_ror) & bus.carry_in, bus.a[7:1]};
                c_out = bus.a[0];
                v_out = res[7] ^ bus.a[0];
                aff = 5'h17;
            end
            default: res = bus.b;
        endcase
    end

    assign bus.result = res;
    assign bus.flags = {v_out, low[4], res[7], res == 8'h00, c_out};
    assign bus.affect = aff;
endmodule : crs_alu

// *** logic/crs_register_set.sv ***
/*
 * visible registers of the 8-bit core: acc, index pair, stack
 * pointer, program counter, flags; vector fetch, irq stacking, halt.
 * assumes a same-clock sequencer giving one command a cycle while
 * cmd_ready is high, and read data in the next cycle only.
 */
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_register_set #(
    parameter int IRQ_W = 8,
    parameter int IRQ_IDX_W = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // sequencer commands
    input wire logic cmd_valid,
    input wire crs_pkg::crs_op_t cmd_op,
    input wire crs_pkg::crs_dest_t cmd_dest,
    input wire crs_pkg::crs_alu_op_t cmd_alu,
    input wire logic [15:0] cmd_data,
    input wire logic instr_boundary,
    output logic cmd_ready,
    // interrupt requests, bit 0 most urgent
    input wire logic [IRQ_W-1:0] irq_request,
    output logic irq_taken,
    output logic [IRQ_IDX_W-1:0] irq_source,
    // memory port
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_write,
    output logic mem_read,
    input wire logic [7:0] mem_rdata,
    // register view
    output logic [7:0] acc,
    output logic [15:0] index_pair,
    output logic [15:0] stack_pointer,
    output logic [15:0] program_counter,
    output logic [7:0] condition_flags,
    output logic [15:0] operand_addr,
    // signed branch conditions and halt
    output logic branch_signed_greater,
    output logic branch_signed_greater_equal,
    output logic branch_signed_less_equal,
    output logic branch_signed_less,
    output logic core_clock_halt
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // shared 16-bit adder
    function automatic logic [15:0] add16(input logic [15:0] x, input logic [15:0] y);
        return x + y;
    endfunction : add16

    // alu flags land only where the operation writes them
    function automatic logic [7:0] merge_flags(input logic [7:0] f, input logic [4:0] nf,
                                               input logic [4:0] en);
        logic [7:0] r;
        r = f;
        if (en[4]) r[`CRS_FLAG_V] = nf[4];
        if (en[3]) r[`CRS_FLAG_H] = nf[3];
        if (en[2]) r[`CRS_FLAG_N] = nf[2];
        if (en[1]) r[`CRS_FLAG_Z] = nf[1];
        if (en[0]) r[`CRS_FLAG_C] = nf[0];
        return r;
    endfunction : merge_flags

    // lowest set bit wins
    function automatic logic [IRQ_IDX_W-1:0] first_request(input logic [IRQ_W-1:0] req);
        first_request = '0;
        for (int k = IRQ_W - 1; k >= 0; k--) begin
            if (req[k]) first_request = k[IRQ_IDX_W-1:0];
        end
    endfunction : first_request

    ////////////////////////////////////////////////////////////////////
    // state and next values

    crs_pkg::crs_state_t state;
    crs_pkg::crs_state_t next_state;
    logic [2:0] push_cnt;
    logic [2:0] next_push_cnt;
    logic [15:0] vec_addr;
    logic [15:0] next_vec_addr;
    crs_pkg::crs_dest_t rd_dest_q1;
    crs_pkg::crs_dest_t rd_dest_q2;
    crs_pkg::crs_dest_t next_rd_dest;
    logic [7:0] next_acc;
    logic [15:0] next_index;
    logic [15:0] next_sp;
    logic [15:0] next_pc;
    logic [7:0] next_flags;
    logic [7:0] next_flags_raw;
    logic [15:0] next_operand_addr;
    logic [15:0] next_mem_addr;
    logic [7:0] next_mem_wdata;
    logic next_mem_write;
    logic next_mem_read;
    logic next_irq_taken;
    logic [IRQ_IDX_W-1:0] next_irq_source;
    logic next_halt;

    crs_alu_if alu_bus ();

    crs_alu u_alu (
        .bus(alu_bus)
    );

    ////////////////////////////////////////////////////////////////////
    // decodes

    wire logic mask = condition_flags[`CRS_FLAG_I];
    wire logic run_cmd = (state == crs_pkg::st_run) && cmd_valid;
    wire logic any_irq = |irq_request;
    // take only at a boundary with the mask clear
    wire logic take_irq = (state == crs_pkg::st_run) && !cmd_valid && instr_boundary
                          && !mask && any_irq;
    wire logic [IRQ_IDX_W-1:0] irq_pick = first_request(irq_request);
    wire logic [15:0] sp_up = add16(stack_pointer, `CRS_ONE16);
    wire logic [15:0] sp_down = add16(stack_pointer, `CRS_SP_STEP_DOWN);
    wire logic [15:0] rel_target = add16(program_counter, {{8{cmd_data[7]}}, cmd_data[7:0]});
    wire logic [15:0] vec_of_pick = `CRS_VEC_IRQ_TOP
                                    - {{(15 - IRQ_IDX_W){1'b0}}, irq_source, 1'b0};
    // stacking order: counter low, counter high, index low, acc, flags
    wire logic [7:0] push_byte = (push_cnt == 3'h0) ? program_counter[7:0] :
                                 (push_cnt == 3'h1) ? program_counter[15:8] :
                                 (push_cnt == 3'h2) ? index_pair[7:0] :
                                 (push_cnt == 3'h3) ? acc : condition_flags;
    wire logic n_xor_v = next_flags[`CRS_FLAG_N] ^ next_flags[`CRS_FLAG_V];

    // alu: accumulator against command byte
    assign alu_bus.op = cmd_alu;
    assign alu_bus.a = acc;
    assign alu_bus.b = cmd_data[7:0];
    assign alu_bus.carry_in = condition_flags[`CRS_FLAG_C];

    ////////////////////////////////////////////////////////////////////
    // next state of every register; a returning pulled byte is applied
    // last, so the sequencer must not touch its target in that cycle

    always_comb begin
        next_state = state;
        next_push_cnt = push_cnt;
        next_vec_addr = vec_addr;
        next_rd_dest = crs_pkg::dest_none;
        next_acc = acc;
        next_index = index_pair;
        next_sp = stack_pointer;
        next_pc = program_counter;
        next_flags_raw = condition_flags;
        next_operand_addr = operand_addr;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_write = 1'b0;
        next_mem_read = 1'b0;
        next_irq_taken = 1'b0;
        next_irq_source = irq_source;
        next_halt = core_clock_halt;
        case (state)
            crs_pkg::st_vec_hi: begin
                next_mem_addr = vec_addr;
                next_mem_read = 1'b1;
                next_rd_dest = crs_pkg::dest_pc_hi;
                next_state = crs_pkg::st_vec_lo;
            end
            crs_pkg::st_vec_lo: begin
                next_mem_addr = add16(vec_addr, `CRS_ONE16);
                next_mem_read = 1'b1;
                next_rd_dest = crs_pkg::dest_pc_lo;
                next_state = crs_pkg::st_vec_wait;
            end
            crs_pkg::st_vec_wait: next_state = crs_pkg::st_vec_end;
            crs_pkg::st_vec_end: next_state = crs_pkg::st_run;
            crs_pkg::st_run: begin
                if (run_cmd) begin
                    // no address decodes these registers
                    case (cmd_op)
                        crs_pkg::op_load_acc: next_acc = cmd_data[7:0];
                        crs_pkg::op_load_index_lo: next_index[7:0] = cmd_data[7:0];
                        crs_pkg::op_load_index_hi: next_index[15:8] = cmd_data[7:0];
                        crs_pkg::op_alu: begin
                            next_acc = alu_bus.result;
                            next_flags_raw = merge_flags(condition_flags, alu_bus.flags,
                                                         alu_bus.affect);
                        end
                        crs_pkg::op_alu_compare: next_flags_raw = merge_flags(condition_flags,
                                                     alu_bus.flags, alu_bus.affect);
                        crs_pkg::op_fetch: next_pc = add16(program_counter, `CRS_ONE16);
                        crs_pkg::op_jump: next_pc = cmd_data;
                        crs_pkg::op_branch: next_pc = rel_target;
                        crs_pkg::op_push, crs_pkg::op_push_upper_index: begin
                            next_mem_addr = stack_pointer;
                            next_mem_wdata = (cmd_op == crs_pkg::op_push) ? cmd_data[7:0]
                                                                           : index_pair[15:8];
                            next_mem_write = 1'b1;
                            next_sp = sp_down;
                        end
                        crs_pkg::op_pull, crs_pkg::op_pull_upper_index: begin
                            next_mem_addr = sp_up;
                            next_mem_read = 1'b1;
                            next_sp = sp_up;
                            next_rd_dest = (cmd_op == crs_pkg::op_pull) ? cmd_dest
                                                                        : crs_pkg::dest_index_hi;
                        end
                        crs_pkg::op_stack_low_reload: next_sp[7:0] = `CRS_SP_LOW_RELOAD;
                        crs_pkg::op_mask_clear: next_flags_raw[`CRS_FLAG_I] = 1'b0;
                        crs_pkg::op_mask_set: next_flags_raw[`CRS_FLAG_I] = 1'b1;
                        crs_pkg::op_addr_stack: next_operand_addr = add16(stack_pointer, cmd_data);
                        crs_pkg::op_addr_index: next_operand_addr = add16(index_pair, cmd_data);
                        crs_pkg::op_wait_stop: begin
                            next_flags_raw[`CRS_FLAG_I] = 1'b0;
                            next_halt = 1'b1;
                            next_state = crs_pkg::st_halt;
                        end
                        default: next_acc = acc;
                    endcase
                end else if (take_irq) begin
                    next_irq_taken = 1'b1;
                    next_irq_source = irq_pick;
                    next_push_cnt = 3'h0;
                    next_state = crs_pkg::st_int_push;
                end
            end
            crs_pkg::st_halt: begin
                // any request wakes; the mask was cleared on the way in
                if (any_irq) begin
                    next_halt = 1'b0;
                    next_irq_taken = 1'b1;
                    next_irq_source = irq_pick;
                    next_push_cnt = 3'h0;
                    next_state = crs_pkg::st_int_push;
                end
            end
            crs_pkg::st_int_push: begin
                next_mem_addr = stack_pointer;
                next_mem_wdata = push_byte;
                next_mem_write = 1'b1;
                next_sp = sp_down;
                if (push_cnt == `CRS_PUSH_LAST) begin
                    next_state = crs_pkg::st_int_mask;
                end else begin
                    next_push_cnt = push_cnt + 3'h1;
                end
            end
            crs_pkg::st_int_mask: begin
                // mask rises after stacking, before the vector read
                next_flags_raw[`CRS_FLAG_I] = 1'b1;
                next_vec_addr = vec_of_pick;
                next_state = crs_pkg::st_vec_hi;
            end
            default: next_state = crs_pkg::st_run;
        endcase
        case (rd_dest_q2)
            crs_pkg::dest_acc: next_acc = mem_rdata;
            crs_pkg::dest_index_lo: next_index[7:0] = mem_rdata;
            crs_pkg::dest_index_hi: next_index[15:8] = mem_rdata;
            crs_pkg::dest_flags: next_flags_raw = mem_rdata;
            crs_pkg::dest_pc_hi: next_pc[15:8] = mem_rdata;
            crs_pkg::dest_pc_lo: next_pc[7:0] = mem_rdata;
            default: next_pc = next_pc;
        endcase
    end

    // bits 6 and 5 can never be stored as zero
    assign next_flags = next_flags_raw | `CRS_FLAG_ONES;

    ////////////////////////////////////////////////////////////////////
    // sequencing flops

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= crs_pkg::st_vec_hi;
            push_cnt <= 3'h0;
            vec_addr <= `CRS_VEC_RESET_HI;
            rd_dest_q1 <= crs_pkg::dest_none;
            rd_dest_q2 <= crs_pkg::dest_none;
        end else begin
            state <= next_state;
            push_cnt <= next_push_cnt;
            vec_addr <= next_vec_addr;
            rd_dest_q1 <= next_rd_dest;
            rd_dest_q2 <= rd_dest_q1;
        end
    end

    // programmer visible registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc <= `CRS_ACC_RESET;
            index_pair <= `CRS_INDEX_RESET;
            stack_pointer <= `CRS_SP_RESET;
            program_counter <= `CRS_PC_RESET;
            condition_flags <= `CRS_FLAGS_RESET;
            operand_addr <= `CRS_INDEX_RESET;
        end else begin
            acc <= next_acc;
            index_pair <= next_index;
            stack_pointer <= next_sp;
            program_counter <= next_pc;
            condition_flags <= next_flags;
            operand_addr <= next_operand_addr;
        end
    end

    // memory strobes stand one cycle, except five writes in a row while stacking and two reads in a row on a vector fetch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= `CRS_INDEX_RESET;
            mem_wdata <= `CRS_ACC_RESET;
            mem_write <= 1'b0;
            mem_read <= 1'b0;
        end else begin
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_write <= next_mem_write;
            mem_read <= next_mem_read;
        end
    end

    // handshakes, interrupt report and halt
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ready <= 1'b0;
            irq_taken <= 1'b0;
            irq_source <= '0;
            core_clock_halt <= 1'b0;
        end else begin
            cmd_ready <= (next_state == crs_pkg::st_run);
            irq_taken <= next_irq_taken;
            irq_source <= next_irq_source;
            core_clock_halt <= next_halt;
        end
    end

    // signed branch conditions
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            branch_signed_greater <= 1'b1;
            branch_signed_greater_equal <= 1'b1;
            branch_signed_less_equal <= 1'b0;
            branch_signed_less <= 1'b0;
        end else begin
            branch_signed_greater <= !(next_flags[`CRS_FLAG_Z] || n_xor_v);
            branch_signed_greater_equal <= !n_xor_v;
            branch_signed_less_equal <= next_flags[`CRS_FLAG_Z] || n_xor_v;
            branch_signed_less <= n_xor_v;
        end
    end

endmodule : crs_register_set

// *** tb/crs_asserts.sv ***
/* port checker of the core register set.
   assumes a bind onto crs_register_set and one clock. */
`timescale 1ns/1ps
module crs_asserts (
    // clock and commands
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire crs_pkg::crs_op_t cmd_op,
    input wire logic [15:0] cmd_data,
    // results
    input wire logic irq_taken,
    input wire logic mem_write,
    input wire logic mem_read,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] condition_flags,
    input wire logic [15:0] operand_addr,
    input wire logic branch_signed_less
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a command counts only where the port is ready
    wire go = cmd_valid & cmd_ready;
    sequence s_stack;
        mem_write [*5];
    endsequence
    ////////////////////////////////////////////////
    AST_SP_RESET: assert property ($rose(reset_n) |-> stack_pointer == 16'h00FF)
        else $error("bad reset sp");
    AST_ONES: assert property (condition_flags[6:5] == 2'b11)
        else $error("bits 6,5 not one");
    AST_PUSH: assert property (go && cmd_op == crs_pkg::op_push |=> mem_write &&
        mem_addr == $past(stack_pointer) && stack_pointer == $past(stack_pointer) - 16'h0001)
        else $error("bad push");
    AST_PULL: assert property (go && cmd_op == crs_pkg::op_pull |=> mem_read &&
        stack_pointer == $past(stack_pointer) + 16'h0001 && mem_addr == stack_pointer)
        else $error("bad pull");
    AST_RELOAD: assert property (go && cmd_op == crs_pkg::op_stack_low_reload |=>
        stack_pointer == {$past(stack_pointer[15:8]), 8'hFF}) else $error("bad reload");
    AST_CLEAR: assert property (go && cmd_op == crs_pkg::op_mask_clear |=> !condition_flags[3])
        else $error("mask not cleared");
    AST_FETCH: assert property (go && cmd_op == crs_pkg::op_fetch |=>
        program_counter == $past(program_counter) + 16'h0001) else $error("bad fetch");
    AST_SP_OFS: assert property (go && cmd_op == crs_pkg::op_addr_stack |=>
        operand_addr == $past(stack_pointer) + $past(cmd_data)) else $error("bad sp offset");
    AST_LESS: assert property (branch_signed_less == (condition_flags[7] ^ condition_flags[2]))
        else $error("signed less wrong");
    AST_ENTRY: assert property (irq_taken |-> ##[0:1] s_stack ##[1:2] condition_flags[3])
        else $error("bad entry");
endmodule : crs_asserts
bind crs_register_set crs_asserts i_crs_asserts (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .irq_taken(irq_taken), .mem_write(mem_write),
    .mem_read(mem_read), .mem_addr(mem_addr), .stack_pointer(stack_pointer), .program_counter(program_counter),
    .condition_flags(condition_flags), .operand_addr(operand_addr), .branch_signed_less(branch_signed_less));

// *** tb/crs_register_set_bench.sv ***
/* bench of the core register set: commands, flags, interrupt entry.
   assumes memory that answers a read with the address low byte xor A5. */
`timescale 1ns/1ps
module crs_register_set_bench;
    logic clk = 0, reset_n = 0, cmd_valid = 0, instr_boundary = 0, cmd_ready, irq_taken, mem_write, mem_read, halt;
    crs_pkg::crs_op_t cmd_op = crs_pkg::op_nop;
    logic [15:0] cmd_data = 16'h0000, mem_addr, index_pair, stack_pointer, program_counter, operand_addr;
    logic [7:0] irq_request = 8'h00, mem_rdata = 8'h00, mem_wdata, acc, flags, r;
    logic [2:0] irq_source;
    logic [23:0] exp_q[$];
    logic [23:0] tbl [3] = '{24'h0F0178, 24'h8080EB, 24'h7F01FC}; // acc, operand, flags after add
    int num_errors = 0, n_checks = 0, seed = 77082, k;
    crs_register_set i_crs_register_set (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_dest(crs_pkg::dest_acc), .cmd_alu(crs_pkg::alu_add), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .instr_boundary(instr_boundary), .irq_request(irq_request), .irq_taken(irq_taken), .irq_source(irq_source),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write), .mem_read(mem_read), .acc(acc),
        .mem_rdata(mem_rdata), .index_pair(index_pair), .stack_pointer(stack_pointer), .condition_flags(flags),
        .program_counter(program_counter), .operand_addr(operand_addr), .branch_signed_greater(),
        .branch_signed_greater_equal(), .branch_signed_less_equal(), .branch_signed_less(), .core_clock_halt(halt));
    initial begin
        forever #2 clk = ~clk;
    end
    // data stands one cycle after the strobe, flips otherwise
    always @(posedge clk) mem_rdata <= mem_read ? mem_addr[7:0] ^ 8'hA5 : ~mem_rdata;
    // every memory write takes the oldest note
    always @(negedge clk) begin
        if (mem_write === 1'b1) chk("write", exp_q.size() ? exp_q.pop_front() : 24'hXXXXXX, {mem_addr, mem_wdata});
    end
    ////////////////////////////////////////////////
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // bounded wait for the run state
    task wait_ready;
        for (k = 0; k < 60 && cmd_ready !== 1'b1; k++) @(negedge clk);
        if (k == 60) begin
            num_errors++;
            give_verdict;
        end
    endtask : wait_ready
    // three falling edges cover the two-edge landing of a pull
    task cmd(input crs_pkg::crs_op_t op, input logic [15:0] d);
        wait_ready;
        @(posedge clk);
        cmd_op <= op;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : cmd
    ////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wait_ready;
        chk("reset pc", {8'hFE ^ 8'hA5, 8'hFF ^ 8'hA5}, program_counter);
        chk("reset sp", 16'h00FF, stack_pointer);
        chk("reset flags", 8'h68, flags);
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            exp_q.push_back({16'h00FF - i[15:0], r});
            cmd(crs_pkg::op_push, {8'h00, r});
        end
        cmd(crs_pkg::op_pull, 16'h0000);
        chk("pull", 8'hFD ^ 8'hA5, acc);
        cmd(crs_pkg::op_stack_low_reload, 16'h0000);
        chk("reload", 16'h00FF, stack_pointer);
        cmd(crs_pkg::op_addr_stack, 16'h0010);
        chk("stack offset", 16'h010F, operand_addr);
        for (int i = 0; i < 3; i++) begin
            cmd(crs_pkg::op_load_acc, {8'h00, tbl[i][23:16]});
            cmd(crs_pkg::op_alu, {8'h00, tbl[i][15:8]});
            chk("flags", tbl[i][7:0], flags);
        end
        cmd(crs_pkg::op_load_index_lo, 16'h003C);
        cmd(crs_pkg::op_load_index_hi, 16'h00C3);
        cmd(crs_pkg::op_addr_index, 16'h0004);
        chk("index offset", 16'hC340, operand_addr);
        cmd(crs_pkg::op_jump, 16'h1234);
        cmd(crs_pkg::op_fetch, 16'h0000);
        cmd(crs_pkg::op_mask_clear, 16'h0000);
        // entry stacks pc, index low, acc and flags; upper index must not show
        exp_q = '{24'h00FF35, 24'h00FE12, 24'h00FD3C, 24'h00FC80, 24'h00FBF4};
        @(posedge clk);
        irq_request <= 8'h06;
        instr_boundary <= 1'b1;
        repeat (3) @(negedge clk);
        wait_ready;
        chk("vector", {8'hF8 ^ 8'hA5, 8'hF9 ^ 8'hA5}, program_counter);
        chk("source", 3'h1, irq_source);
        chk("mask", 1'b1, flags[3]);
        chk("unwritten", 24'h000000, exp_q.size());
        @(posedge clk);
        irq_request <= 8'h00;
        cmd(crs_pkg::op_wait_stop, 16'h0000);
        chk("halt", 2'b10, {halt, flags[3]});
        // a reset during the halt wakes the core with the mask set
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wait_ready;
        chk("reset wake", 2'b01, {halt, flags[3]});
        give_verdict;
    end
endmodule : crs_register_set_bench
